//--- flrp_pkg.sv
// Purpose: Constants for the fuse and lock readback / protection block
// Assumes: 100 MHz sys_clk, 8-bit control register image
// Notes:   Nonvolatile bytes are held as bit patterns, 0 = programmed
package flrp_pkg;
    localparam int unsigned CLK_HZ           = 100_000_000;
    localparam logic [15:0] PTR_FUSE_LOW     = 16'h0000;
    localparam logic [15:0] PTR_LOCK         = 16'h0001;
    localparam logic [15:0] PTR_FUSE_HIGH    = 16'h0003;
    localparam int unsigned BIT_STORE_EN     = 0;
    localparam int unsigned BIT_PAGE_ERASE   = 1;
    localparam int unsigned BIT_PAGE_WRITE   = 2;
    localparam int unsigned BIT_READ_SELECT  = 3;
    localparam logic [2:0]  LOAD_WINDOW      = 3'h3;
    localparam logic [2:0]  STORE_WINDOW     = 3'h4;
    localparam logic [7:0]  LOCK_RESET       = 8'hff;
    localparam logic [7:0]  FUSE_LOW_RESET   = 8'h62;
    localparam logic [7:0]  FUSE_HIGH_RESET  = 8'hdf;
    localparam int unsigned DEBUG_FUSE_BIT   = 6;
    localparam int unsigned WRITE_MIN_US     = 3700;
    localparam int unsigned WRITE_MAX_US     = 4500;
    // Least time in whole cycles; cycles per microsecond truncated, no rounding up
    localparam int unsigned WRITE_CYCLES     = (WRITE_MIN_US * (CLK_HZ / 1_000_000) + 0);
    localparam int unsigned WRITE_MAX_CYCLES = WRITE_MAX_US * (CLK_HZ / 1_000_000);
    typedef enum logic [2:0] {
        FLRP_IDLE  = 3'b001,
        FLRP_ARMED = 3'b010,
        FLRP_BUSY  = 3'b100
    } flrp_state_type;
endpackage

//--- flrp_fuse_lock.sv
// Purpose: Fuse and lock byte readback for the core, lock protection decode,
//          and timing of nonvolatile writes issued by the store instruction
// Assumes: Core presents one-cycle strobes for control writes, loads, stores
// Notes:   Lock and fuse storage has no reset; the timed write does
// Overview of operation
// - Pointer 0x0001 armed load returns lock byte
// - Auto-clear arm bits after read or timeout
// - Unarmed load returns flash data unchanged
// - Pointer 0x0000 armed load returns fuse low
// - Pointer 0x0003 armed load returns fuse high
// - Programmed reads zero, unprogrammed reads one
// - Nonvolatile writes timed 3.7 to 4.5 ms
// - Reset aborts a write in progress
// - Two lock bits at 1:0, rest ones
// - Lock bits erase only by chip erase
// - Debug fuse programmed keeps debug readout allowed
// - Mode 1 applies no restrictions
// - Mode 2 blocks programming and fuses; debug readout follows the debug fuse only
// - Mode 3 additionally blocks verification reads
// - Read-select at control bit 3
// - Store-enable at bit 0, short window
// - Data-memory write blocks fuse/lock readback
`timescale 1ns/1ps
`default_nettype none
module flrp_fuse_lock #(
    parameter int unsigned WRITE_CYCLES_P = flrp_pkg::WRITE_CYCLES
) (
    input  wire logic        sys_clk,          // Core clock, 100 MHz
    input  wire logic        reset_n,          // Async reset, active low
    input  wire logic        ctrl_wr,          // Control register write strobe
    input  wire logic [7:0]  ctrl_wdata,       // Control register write data
    output logic      [7:0]  program_memory_control_reg, // Control register image
    input  wire logic        load_program_memory_instr,  // Load instruction strobe
    input  wire logic        store_program_memory_instr, // Store instruction strobe
    input  wire logic [15:0] addr_ptr,         // Address pointer
    input  wire logic [7:0]  flash_rdata,      // Flash byte at pointer
    output logic      [7:0]  load_result,      // Load destination data
    output logic             load_result_vld,  // Load result valid pulse
    input  wire logic        eeprom_busy,      // Data-memory write in progress
    input  wire logic        lock_wr_lower,    // Program lower lock bit
    input  wire logic        lock_wr_upper,    // Program upper lock bit
    input  wire logic        chip_erase,       // Whole-chip erase pulse
    input  wire logic        fuse_wr,          // External fuse write strobe
    input  wire logic        fuse_sel_high,    // Fuse write selects high byte
    input  wire logic [7:0]  fuse_wdata,       // Fuse write value
    output logic             nv_busy,          // Nonvolatile write in progress
    output logic             ext_prog_allow,   // External programming allowed
    output logic             ext_verify_allow, // External verify reads allowed
    output logic             fuse_write_allow, // Fuse changes allowed
    output logic             debug_read_allow  // Debug link readout allowed
);
    import flrp_pkg::*;

    flrp_state_type state_q;
    logic [2:0]  win_q;
    logic        rsel_q;
    logic        sen_q;
    logic [1:0]  op_q;
    logic [31:0] tmr_q;
    logic [7:0]  lock_q;
    logic [7:0]  fuse_lo_q;
    logic [7:0]  fuse_hi_q;
    logic        ctrl_ok;
    logic        armed_rd;
    logic        lb_lo;
    logic        lb_hi;

    function automatic logic [7:0] nv_read(input logic [15:0] p, input logic [7:0] lk,
                                           input logic [7:0] flo, input logic [7:0] fhi);
        case (p)
            PTR_LOCK:      nv_read = lk;
            PTR_FUSE_LOW:  nv_read = flo;
            PTR_FUSE_HIGH: nv_read = fhi;
            default:       nv_read = 8'hff;
        endcase
    endfunction

    // Only documented combinations arm anything; blocked during data writes
    assign ctrl_ok  = ctrl_wr && !eeprom_busy && state_q != FLRP_BUSY &&
                      ctrl_wdata[7:4] == 4'h0 && ctrl_wdata[BIT_STORE_EN] &&
                      (ctrl_wdata[3:1] == 3'b100 || ctrl_wdata[3:1] == 3'b010 ||
                       ctrl_wdata[3:1] == 3'b001 || ctrl_wdata[3:1] == 3'b000);
    assign armed_rd = state_q == FLRP_ARMED && rsel_q && sen_q && !eeprom_busy &&
                      win_q < LOAD_WINDOW;
    assign lb_lo    = lock_q[0];
    assign lb_hi    = lock_q[1];

    // Arm window and write sequencing
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= FLRP_IDLE;
            win_q   <= 3'h0;
            rsel_q  <= 1'b0;
            sen_q   <= 1'b0;
            op_q    <= 2'b00;
            tmr_q   <= 32'h0;
        end else begin
            case (state_q)
                FLRP_IDLE: begin
                    if (ctrl_ok) begin
                        state_q <= FLRP_ARMED;
                        win_q   <= 3'h0;
                        rsel_q  <= ctrl_wdata[BIT_READ_SELECT];
                        sen_q   <= 1'b1;
                        op_q    <= ctrl_wdata[2:1];
                    end
                end
                FLRP_ARMED: begin
                    win_q <= win_q + 3'h1;
                    if (rsel_q && load_program_memory_instr && armed_rd) begin
                        state_q <= FLRP_IDLE;
                        rsel_q  <= 1'b0;
                        sen_q   <= 1'b0;
                    end else if (store_program_memory_instr && win_q < STORE_WINDOW) begin
                        rsel_q <= 1'b0;
                        if (op_q != 2'b00 || lock_wr_lower || lock_wr_upper) begin
                            state_q <= FLRP_BUSY;
                            tmr_q   <= 32'h0;
                        end else begin
                            state_q <= FLRP_IDLE;
                            sen_q   <= 1'b0;
                        end
                    end else if ((rsel_q && win_q + 3'h1 >= LOAD_WINDOW) ||
                                 win_q + 3'h1 >= STORE_WINDOW) begin
                        state_q <= FLRP_IDLE;
                        rsel_q  <= 1'b0;
                        sen_q   <= 1'b0;
                        op_q    <= 2'b00;
                    end
                end
                FLRP_BUSY: begin
                    tmr_q <= tmr_q + 32'h1;
                    if (tmr_q + 32'h1 >= 32'(WRITE_CYCLES_P)) begin
                        state_q <= FLRP_IDLE;
                        sen_q   <= 1'b0;
                        op_q    <= 2'b00;
                    end
                end
                default: state_q <= FLRP_IDLE;
            endcase
        end
    end

    // Nonvolatile contents survive core reset, so no async reset here
    always_ff @(posedge sys_clk) begin
        if (chip_erase) begin
            lock_q <= LOCK_RESET;
        end else begin
            lock_q[0] <= lock_q[0] & ~lock_wr_lower;
            lock_q[1] <= lock_q[1] & ~lock_wr_upper;
            lock_q[7:2] <= 6'h3f;
        end
        if (fuse_wr && lb_lo) begin
            if (fuse_sel_high) begin
                fuse_hi_q <= fuse_wdata;
            end else begin
                fuse_lo_q <= fuse_wdata;
            end
        end
    end

    // Readback path; stored bytes already use 0 = programmed
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            load_result     <= 8'hff;
            load_result_vld <= 1'b0;
        end else begin
            load_result_vld <= load_program_memory_instr;
            if (load_program_memory_instr) begin
                if (rsel_q && armed_rd) begin
                    load_result <= nv_read(addr_ptr, lock_q, fuse_lo_q, fuse_hi_q);
                end else begin
                    load_result <= flash_rdata;
                end
            end
        end
    end

    // Protection mode decode
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ext_prog_allow   <= 1'b0;
            ext_verify_allow <= 1'b0;
            fuse_write_allow <= 1'b0;
            debug_read_allow <= 1'b0;
            nv_busy          <= 1'b0;
            program_memory_control_reg <= 8'h00;
        end else begin
            ext_prog_allow   <= lb_lo;
            ext_verify_allow <= lb_lo | lb_hi;
            fuse_write_allow <= lb_lo;
            // Debug fuse programmed overrides lock for readout
            debug_read_allow <= ~fuse_hi_q[DEBUG_FUSE_BIT];
            nv_busy          <= state_q == FLRP_BUSY;
            program_memory_control_reg <= {4'h0, rsel_q, op_q, sen_q};
        end
    end
endmodule
`default_nettype wire

//--- flrp_fuse_lock_monitor.sv
// Purpose: Port checks on the fuse and lock readback block
// Assumes: Single sys_clk domain, async active-low reset
// Notes:   Sees only top-level ports; bound below
`timescale 1ns/1ps
`default_nettype none
module flrp_fuse_lock_monitor import flrp_pkg::*; #(
    parameter int unsigned WRITE_CYCLES_P = WRITE_CYCLES
) (
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic        ctrl_wr,
    input wire logic        load_program_memory_instr,
    input wire logic [15:0] addr_ptr,
    input wire logic [7:0]  flash_rdata,
    input wire logic [7:0]  load_result,
    input wire logic        load_result_vld,
    input wire logic [7:0]  program_memory_control_reg,
    input wire logic        eeprom_busy,
    input wire logic        nv_busy,
    input wire logic        ext_prog_allow,
    input wire logic        ext_verify_allow,
    input wire logic        fuse_write_allow
);
    logic        ld;
    logic        armed;
    int unsigned busy_q;
    assign ld = load_program_memory_instr;
    assign armed = program_memory_control_reg == 8'h09;
    // Length of the current timed write
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n)
            busy_q <= 0;
        else
            busy_q <= nv_busy ? busy_q + 1 : 0;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    AST_LOAD_ANSWER: assert property (ld |=> load_result_vld) else $error("load not answered");
    AST_VLD_CAUSE: assert property (load_result_vld |-> $past(ld)) else $error("stray valid");
    AST_PLAIN_LOAD: assert property (ld && program_memory_control_reg == 8'h00 && !ctrl_wr
        |=> load_result == $past(flash_rdata)) else $error("unarmed load not flash");
    AST_BUSY_BLOCKS: assert property (ld && eeprom_busy
        |=> load_result == $past(flash_rdata)) else $error("readback during data write");
    AST_LOCK_PAD: assert property (ld && armed && !eeprom_busy && addr_ptr == PTR_LOCK
        |=> load_result[7:2] == 6'h3f) else $error("lock byte upper bits not ones");
    AST_CLEAR_DONE: assert property (ld && armed && !eeprom_busy
        |=> ##1 program_memory_control_reg == 8'h00) else $error("arm bits kept after read");
    AST_CLEAR_IDLE: assert property (not (armed [*5])) else $error("arm bits never expire");
    AST_FUSE_FREEZE: assert property (fuse_write_allow == ext_prog_allow) else $error("fuse lock mismatch");
    AST_VERIFY_MODE: assert property (!ext_verify_allow |-> !ext_prog_allow) else $error("verify mode");
    AST_WRITE_TIME: assert property ($fell(nv_busy) |-> busy_q >= WRITE_CYCLES_P
        && busy_q <= 2 * WRITE_CYCLES_P) else $error("write time out of range");
    cover property (ld && armed);
    cover property (ld && eeprom_busy);
    cover property ($fell(nv_busy));
endmodule
bind flrp_fuse_lock flrp_fuse_lock_monitor #(.WRITE_CYCLES_P(WRITE_CYCLES_P)) flrp_fuse_lock_monitor_inst (.*);
`default_nettype wire

//--- flrp_core_model.sv
// Purpose: Flash side of the core for load instructions
// Assumes: Combinational flash read at the pointer
// Notes:   Pattern mixes both pointer bytes so stale data shows
`timescale 1ns/1ps
`default_nettype none
module flrp_core_model (
    input  wire logic [15:0] addr_ptr,   // Pointer from core
    output logic      [7:0]  flash_rdata // Flash byte at pointer
);
    assign flash_rdata = addr_ptr[7:0] ^ addr_ptr[15:8] ^ 8'ha5;
endmodule
`default_nettype wire

//--- testbench.sv
// Purpose: Directed tests of fuse and lock readback and protection
// Assumes: Shortened write time of 20 cycles
// Notes:   Nonvolatile bytes set up by chip erase and fuse writes
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import flrp_pkg::*;
    localparam int unsigned WC = 20;
    logic        sys_clk, reset_n, ctrl_wr, ld, st, eeprom_busy, lw_lo, lw_hi;
    logic        erase, fuse_wr, fsel, vld, nvb, pa, va, fa, da;
    logic [7:0]  cdat, fwd, creg, res, fdat;
    logic [15:0] ap;
    int          num_errors = 0, checks = 0, cyc = 0, n;
    flrp_fuse_lock #(.WRITE_CYCLES_P(WC)) flrp_fuse_lock_inst (.sys_clk(sys_clk), .reset_n(reset_n),
        .ctrl_wr(ctrl_wr), .ctrl_wdata(cdat), .program_memory_control_reg(creg), .load_program_memory_instr(ld),
        .store_program_memory_instr(st), .addr_ptr(ap), .flash_rdata(fdat), .load_result(res),
        .load_result_vld(vld), .eeprom_busy(eeprom_busy), .lock_wr_lower(lw_lo), .lock_wr_upper(lw_hi),
        .chip_erase(erase), .fuse_wr(fuse_wr), .fuse_sel_high(fsel), .fuse_wdata(fwd), .nv_busy(nvb),
        .ext_prog_allow(pa), .ext_verify_allow(va), .fuse_write_allow(fa), .debug_read_allow(da));
    flrp_core_model flrp_core_model_inst (.addr_ptr(ap), .flash_rdata(fdat));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    function automatic logic [7:0] fl(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'ha5;
    endfunction
    task automatic chk(input logic ok);
        checks++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("ERROR %0t mismatch", $time);
        end
    endtask
    task automatic cw(input logic [7:0] d);
        @(posedge sys_clk);
        ctrl_wr <= 1'b1;
        cdat <= d;
        @(posedge sys_clk);
        ctrl_wr <= 1'b0;
    endtask
    task automatic ldc(input logic [15:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        ld <= 1'b1;
        ap <= a;
        @(posedge sys_clk);
        ld <= 1'b0;
        @(negedge sys_clk);
        chk(vld === 1'b1 && res === e);
    endtask
    // Erase/lock pulses and fuse writes, then wait out any timed write
    task automatic op(input logic [2:0] w, input logic h, input logic [7:0] d);
        @(posedge sys_clk);
        {erase, lw_hi, lw_lo} <= w;
        {fuse_wr, fsel, fwd} <= {w == 3'b000, h, d};
        @(posedge sys_clk);
        {erase, lw_hi, lw_lo, fuse_wr} <= 4'h0;
        repeat (2 * WC + 5) @(posedge sys_clk);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        {reset_n, ctrl_wr, ld, st, eeprom_busy, lw_lo, lw_hi, erase, fuse_wr, fsel} = '0;
        {cdat, fwd, ap} = 32'h0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        op(3'b100, 1'b0, 8'h00);
        op(3'b000, 1'b0, FUSE_LOW_RESET);
        op(3'b000, 1'b1, FUSE_HIGH_RESET);
        chk({pa, va, fa} === 3'b111);
        chk(da === ~FUSE_HIGH_RESET[DEBUG_FUSE_BIT]);
        ldc(16'h1234, fl(16'h1234));
        cw(8'h09);
        ldc(PTR_LOCK, 8'hff);
        @(negedge sys_clk);
        chk(creg === 8'h00);
        cw(8'h09);
        ldc(PTR_FUSE_LOW, FUSE_LOW_RESET);
        cw(8'h09);
        ldc(PTR_FUSE_HIGH, FUSE_HIGH_RESET);
        $display("test readback done");
        cw(8'h09);
        repeat (5) @(posedge sys_clk);
        chk(creg === 8'h00);
        ldc(PTR_LOCK, fl(PTR_LOCK));
        cw(8'h09);
        eeprom_busy <= 1'b1;
        ldc(PTR_LOCK, fl(PTR_LOCK));
        eeprom_busy <= 1'b0;
        repeat (5) @(posedge sys_clk);
        $display("test expiry done");
        cw(8'h05);
        st <= 1'b1;
        @(posedge sys_clk);
        st <= 1'b0;
        n = 0;
        repeat (2 * WC + 10) begin
            @(posedge sys_clk);
            if (nvb === 1'b1)
                n++;
        end
        chk(n >= WC && n <= 2 * WC);
        op(3'b001, 1'b0, 8'h00);
        chk({pa, va, fa} === 3'b010);
        op(3'b000, 1'b1, 8'h00);
        cw(8'h09);
        ldc(PTR_FUSE_HIGH, FUSE_HIGH_RESET);
        op(3'b010, 1'b0, 8'h00);
        chk({pa, va, fa} === 3'b000);
        reset_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        cw(8'h09);
        ldc(PTR_LOCK, 8'hfc);
        op(3'b100, 1'b0, 8'h00);
        cw(8'h09);
        ldc(PTR_LOCK, 8'hff);
        chk({pa, va, fa} === 3'b111);
        $display("test protection done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
